//--- rtl/status_ctl.sv
// Processor status control: status register, interrupt gating, mode decode,
// bus-error masking and serial-debug exception gating.
// Assumes core event inputs are one-cycle pulses on the core clock and the
// external interrupt and serial-debug pins are asynchronous levels.
//
// The register offsets and the Avalon-MM register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module status_ctl (
  // Clock and reset.
  input  wire logic                                  sys_clk_in,
  input  wire logic                                  nrst_in,
  // Avalon-MM register port.
  input  wire logic [status_ctl_pkg::ADDR_W-1:0]     avs_address_in,
  input  wire logic                                  avs_read_in,
  input  wire logic                                  avs_write_in,
  input  wire logic [31:0]                           avs_writedata_in,
  input  wire logic [3:0]                            avs_byteenable_in,
  output logic [31:0]                                avs_readdata_out,
  output logic                                       avs_waitrequest_out,
  // Core instruction and exception events.
  input  wire logic                                  enable_interrupts_instr_in,
  input  wire logic                                  disable_interrupts_instr_in,
  input  wire logic                                  level2_exc_taken_in,
  input  wire logic                                  general_exc_taken_in,
  input  wire logic                                  bus_error_in,
  input  wire logic [31:0]                           bus_error_addr_in,
  // Interrupt sources.
  input  wire logic                                  timer_intr_in,
  input  wire logic [1:0]                            ext_intr_in,
  input  wire logic                                  serial_debug_input_in,
  // Address region query.
  input  wire status_ctl_pkg::region_t               access_region_in,
  // Results to the core.
  output logic [status_ctl_pkg::NUM_SRC-1:0]         intr_take_out,
  output logic                                       intr_req_out,
  output logic                                       bus_error_exc_out,
  output logic                                       serial_debug_exc_out,
  output status_ctl_pkg::mode_t                      mode_out,
  output logic                                       access_ok_out
);
  import status_ctl_pkg::*;

  status_t              status_ff;
  status_t              nxt_status;
  logic [31:0]          bad_physical_address_reg_ff;
  logic [31:0]          nxt_bad_physical_address_reg;
  logic                 bus_error_exc_ff;
  logic                 nxt_bus_error_exc;
  logic                 serial_debug_exc_ff;
  logic                 nxt_serial_debug_exc;
  logic                 sdbg_prev_ff;
  logic [NUM_SRC-1:0]   intr_take_ff;
  logic [NUM_SRC-1:0]   nxt_intr_take;
  logic                 access_ok_ff;
  logic                 rd_valid_ff;
  logic                 nxt_rd_valid;
  logic [31:0]          readdata_ff;
  logic [31:0]          nxt_readdata;
  logic [1:0]           ext_sync;
  logic                 sdbg_sync;
  logic [NUM_SRC-1:0]   intr_pending_bits;
  logic [NUM_SRC-1:0]   intr_mask_bits;
  logic                 intr_enabled;
  logic                 instr_permitted;
  logic                 wr_status;
  logic [31:0]          lane_mask;
  logic [31:0]          state_word;
  logic                 access_ok;
  mode_t                mode;

  // Asynchronous pins pass two flip-flops first.
  pin_sync #(.WIDTH(3)) u_pin_sync (
    .sys_clk_in (sys_clk_in),
    .nrst_in    (nrst_in),
    .pin_in     ({serial_debug_input_in, ext_intr_in}),
    .sync_out   ({sdbg_sync, ext_sync})
  );

  // Mode and region permission come from the registered status.
  mode_decode u_mode_decode (
    .privilege_field_in (status_ff.privilege_field),
    .exception_level_in (status_ff.exception_level),
    .error_level_in     (status_ff.error_level),
    .region_in          (access_region_in),
    .mode_out           (mode),
    .access_ok_out      (access_ok)
  );

  // Interrupt source mapping and the combined enable condition.
  assign intr_pending_bits = {timer_intr_in, ext_sync}; // RULE_07
  assign intr_mask_bits    = {status_ff.intr_mask_timer, status_ff.intr_mask_ext}; // RULE_07
  assign intr_enabled      = status_ff.global_intr_enable && status_ff.enable_of_enable &&
                             !status_ff.exception_level && !status_ff.error_level; // RULE_04 RULE_05
  assign instr_permitted   = status_ff.intr_instr_enable || (mode == MODE_KERNEL); // RULE_01 RULE_02

  // Bus decode; byte enables select which lanes a write touches.
  assign wr_status = avs_write_in && (avs_address_in == OFS_STATUS);
  assign lane_mask = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
                      {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};

  // Read-only view of the live state.
  always_comb
  begin
    state_word = '0;
    state_word[ST_INTR_EN] = intr_enabled;
    state_word[ST_MODE_LO +: 4] = mode;
    state_word[ST_PEND_LO +: NUM_SRC] = intr_pending_bits;
    state_word[ST_SDBG] = sdbg_sync;
  end

  // Status update: software write first, hardware events after so they win.
  always_comb
  begin
    nxt_status = status_ff;
    nxt_bad_physical_address_reg = bad_physical_address_reg_ff;
    nxt_bus_error_exc = 1'b0;
    if (wr_status)
      nxt_status = status_t'((status_ff & ~lane_mask) |
                             (avs_writedata_in & lane_mask & STATUS_WMASK)); // RULE_18
    if (enable_interrupts_instr_in && instr_permitted)
      nxt_status.enable_of_enable = 1'b1; // RULE_03
    else if (disable_interrupts_instr_in && instr_permitted)
      nxt_status.enable_of_enable = 1'b0; // RULE_03
    if (bus_error_in && !status_ff.bus_error_mask)
    begin
      nxt_bad_physical_address_reg = bus_error_addr_in; // RULE_08
      nxt_bus_error_exc = 1'b1; // RULE_08
      nxt_status.bus_error_mask = 1'b1; // RULE_09
    end
    if (level2_exc_taken_in)
      nxt_status.error_level = 1'b1; // RULE_13
    if (general_exc_taken_in)
      nxt_status.exception_level = 1'b1; // RULE_14
  end

  // Interrupt take and serial-debug exception decisions.
  always_comb
  begin
    nxt_intr_take = intr_pending_bits & intr_mask_bits & {NUM_SRC{intr_enabled}}; // RULE_06
    nxt_serial_debug_exc = sdbg_sync && !sdbg_prev_ff && !status_ff.error_level; // RULE_16
  end

  // Bus read: first cycle captures data, second cycle answers.
  always_comb
  begin
    nxt_rd_valid = avs_read_in && !rd_valid_ff;
    nxt_readdata = readdata_ff;
    if (avs_read_in && !rd_valid_ff)
    begin
      case (avs_address_in)
        OFS_STATUS:   nxt_readdata = status_ff; // RULE_15
        OFS_BAD_PHYSICAL_ADDRESS_REG: nxt_readdata = bad_physical_address_reg_ff;
        OFS_STATE:    nxt_readdata = state_word;
        default:      nxt_readdata = '0;
      endcase
    end
  end

  // State registers; status resets with only error level and vector select at one.
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      status_ff <= status_t'(STATUS_RESET); // RULE_20
      bad_physical_address_reg_ff <= BADPA_RESET;
      bus_error_exc_ff <= 1'b0;
      serial_debug_exc_ff <= 1'b0;
      sdbg_prev_ff <= 1'b0;
      intr_take_ff <= '0;
      access_ok_ff <= 1'b0;
      rd_valid_ff <= 1'b0;
      readdata_ff <= '0;
    end
    else
    begin
      status_ff <= nxt_status; // RULE_19
      bad_physical_address_reg_ff <= nxt_bad_physical_address_reg;
      bus_error_exc_ff <= nxt_bus_error_exc;
      serial_debug_exc_ff <= nxt_serial_debug_exc;
      sdbg_prev_ff <= sdbg_sync;
      intr_take_ff <= nxt_intr_take;
      access_ok_ff <= access_ok;
      rd_valid_ff <= nxt_rd_valid;
      readdata_ff <= nxt_readdata;
    end
  end

  // Outputs.
  assign avs_readdata_out     = readdata_ff;
  assign avs_waitrequest_out  = avs_read_in && !rd_valid_ff;
  assign intr_take_out        = intr_take_ff;
  assign intr_req_out         = |intr_take_ff;
  assign bus_error_exc_out    = bus_error_exc_ff;
  assign serial_debug_exc_out = serial_debug_exc_ff;
  assign mode_out             = mode;
  assign access_ok_out        = access_ok_ff;

  // Checks on the block's own behaviour.
  property p_en_any_mode;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      enable_interrupts_instr_in && status_ff.intr_instr_enable |=> status_ff.enable_of_enable;
  endproperty
  a_en_any_mode: assert property (p_en_any_mode) // RULE_01
    else $error("Enable instruction ignored");

  property p_dis_noop;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      disable_interrupts_instr_in && !status_ff.intr_instr_enable && mode != MODE_KERNEL &&
      !wr_status |=> $stable(status_ff.enable_of_enable);
  endproperty
  a_dis_noop: assert property (p_dis_noop) // RULE_02
    else $error("Disable instruction acted outside kernel");

  property p_dis_kernel;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      disable_interrupts_instr_in && !enable_interrupts_instr_in && mode == MODE_KERNEL
      |=> !status_ff.enable_of_enable;
  endproperty
  a_dis_kernel: assert property (p_dis_kernel) // RULE_03
    else $error("Disable instruction failed in kernel");

  property p_eoe_blocks;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      !status_ff.enable_of_enable |=> intr_take_out == '0;
  endproperty
  a_eoe_blocks: assert property (p_eoe_blocks) // RULE_04
    else $error("Interrupt taken with enable-of-enable clear");

  property p_take_cause;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      intr_req_out |-> $past(intr_enabled) && |($past(intr_mask_bits) & intr_take_out);
  endproperty
  a_take_cause: assert property (p_take_cause) else $error("Interrupt taken without enable"); // RULE_06

  property p_berr_record;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      bus_error_in && !status_ff.bus_error_mask |=>
      bus_error_exc_out && status_ff.bus_error_mask &&
      bad_physical_address_reg_ff == $past(bus_error_addr_in);
  endproperty
  a_berr_record: assert property (p_berr_record) else $error("Bus error not recorded"); // RULE_08

  property p_berr_masked;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      bus_error_in && status_ff.bus_error_mask |=>
      !bus_error_exc_out && $stable(bad_physical_address_reg_ff);
  endproperty
  a_berr_masked: assert property (p_berr_masked) else $error("Masked bus error acted"); // RULE_09

  property p_user_mode;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      mode == MODE_USER |-> status_ff.privilege_field == PRIV_USER &&
      !status_ff.exception_level && !status_ff.error_level;
  endproperty
  a_user_mode: assert property (p_user_mode) else $error("User mode decode wrong"); // RULE_10

  property p_kernel_mode;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      status_ff.exception_level || status_ff.error_level |-> mode == MODE_KERNEL;
  endproperty
  a_kernel_mode: assert property (p_kernel_mode) else $error("Kernel mode not forced"); // RULE_12

  property p_levels_set;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      general_exc_taken_in |=> status_ff.exception_level;
  endproperty
  a_levels_set: assert property (p_levels_set) else $error("Exception level not set"); // RULE_14

  // Level-2 exceptions always leave the error level set.
  property p_erl_set;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      level2_exc_taken_in |=> status_ff.error_level;
  endproperty
  a_erl_set: assert property (p_erl_set) else $error("Error level not set"); // RULE_13

  property p_rsv_zero;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      avs_read_in && !rd_valid_ff && avs_address_in == OFS_STATUS |=>
      (avs_readdata_out & ~STATUS_WMASK) == '0;
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("Reserved bits read nonzero"); // RULE_15

  property p_sdbg_gate;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      serial_debug_exc_out |-> !$past(status_ff.error_level, 1);
  endproperty
  a_sdbg_gate: assert property (p_sdbg_gate) // RULE_16
    else $error("Debug exception with error level set");

  property p_region;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      access_region_in == REGION_KERNEL && mode != MODE_KERNEL |=> !access_ok_out;
  endproperty
  a_region: assert property (p_region) else $error("Kernel region open outside kernel"); // RULE_17

  c_intr_taken: cover property (@(posedge sys_clk_in) disable iff (!nrst_in) intr_req_out);
  c_bus_error: cover property (@(posedge sys_clk_in) disable iff (!nrst_in) bus_error_exc_out);
  c_sdbg_exc: cover property (@(posedge sys_clk_in) disable iff (!nrst_in) serial_debug_exc_out);
  c_user_mode: cover property (@(posedge sys_clk_in) disable iff (!nrst_in) mode == MODE_USER);

endmodule

`default_nettype wire

//--- rtl/status_ctl_pkg.sv
// Shared constants, field layouts and types of the processor status control block.
// Assumes a single core clock domain and a word-wide Avalon-MM register port.
//
// Operation
// RULE_01 - Instruction-enable bit 17 set: enable/disable-interrupt instructions work in all modes.
// RULE_02 - Instruction-enable clear: those instructions do nothing outside kernel mode.
// RULE_03 - Enable-interrupts sets, disable-interrupts clears enable-of-enable bit 16.
// RULE_04 - Enable-of-enable at zero blocks every maskable interrupt.
// RULE_05 - Interrupts enabled only with global enable, enable-of-enable, both levels clear.
// RULE_06 - Mask bits 15 and 11:10 gate sources; taken when enabled, masked, pending.
// RULE_07 - Mask bit 15 is the timer, bits 11:10 the two external lines.
// RULE_08 - Unmasked bus error records its address and raises a bus error exception.
// RULE_09 - Masked bus error does nothing; hardware sets the mask on an unmasked one.
// RULE_10 - User mode when privilege field is 10 and both levels clear.
// RULE_11 - Supervisor mode when privilege field is 01 and both levels clear.
// RULE_12 - Kernel mode when privilege field is 00 or either level is set.
// RULE_13 - Error level set by level-2 exceptions and reads one after reset.
// RULE_14 - Exception level set by every other exception taken.
// RULE_15 - Reserved status bits always read zero; software writes zero there.
// RULE_16 - Serial-debug assertion raises a debug exception only while error level clear.
// RULE_17 - Kernel region kernel only, supervisor region kernel or supervisor, user all.
// RULE_18 - Every non-reserved status bit is readable and writable by software.
// RULE_19 - A status write takes effect from the following cycle onward.
// RULE_20 - Only error level is forced to one at reset; other fields unconstrained. The code also resets boot_vec bit 22 to one.

package status_ctl_pkg;

  // Register byte offsets on the bus.
  localparam int unsigned ADDR_W       = 4;
  localparam logic [3:0]  OFS_STATUS   = 4'h0;
  localparam logic [3:0]  OFS_BAD_PHYSICAL_ADDRESS_REG = 4'h4;
  localparam logic [3:0]  OFS_STATE    = 4'h8;

  // Writable bits and reset image of the status register.
  localparam logic [31:0] STATUS_WMASK = 32'hf4c79c1f;
  localparam logic [31:0] STATUS_RESET = 32'h00400004;
  localparam logic [31:0] BADPA_RESET  = 32'h00000000;

  // Privilege field encodings.
  localparam logic [1:0] PRIV_KERNEL = 2'h0;
  localparam logic [1:0] PRIV_SUPER  = 2'h1;
  localparam logic [1:0] PRIV_USER   = 2'h2;

  // Layout of the read-only state word.
  localparam int unsigned ST_INTR_EN = 0;
  localparam int unsigned ST_MODE_LO = 4;
  localparam int unsigned ST_PEND_LO = 8;
  localparam int unsigned ST_SDBG    = 12;
  localparam int unsigned NUM_SRC    = 3;

  // Status register as seen by the logic, bit 31 first.
  typedef struct packed {
    logic [3:0] cop_usable;
    logic       rsv27;
    logic       fp_regs;
    logic [1:0] rsv25_24;
    logic       dbg_vec;
    logic       boot_vec;
    logic [2:0] rsv21_19;
    logic       cache_hit;
    logic       intr_instr_enable;
    logic       enable_of_enable;
    logic       intr_mask_timer;
    logic [1:0] rsv14_13;
    logic       bus_error_mask;
    logic [1:0] intr_mask_ext;
    logic [4:0] rsv9_5;
    logic [1:0] privilege_field;
    logic       error_level;
    logic       exception_level;
    logic       global_intr_enable;
  } status_t;

  // Operating mode, one-hot; reserved covers privilege field 11.
  typedef enum logic [3:0] {
    MODE_KERNEL = 4'b0001,
    MODE_SUPER  = 4'b0010,
    MODE_USER   = 4'b0100,
    MODE_RSVD   = 4'b1000
  } mode_t;

  // Address region of an access query.
  typedef enum logic [1:0] {
    REGION_KERNEL = 2'h0,
    REGION_SUPER  = 2'h1,
    REGION_USER   = 2'h2
  } region_t;

endpackage

//--- rtl/pin_sync.sv
// Two-stage synchroniser for pins that arrive from outside the core clock.
// Assumes the pins are static levels sampled by the core clock.
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset.
  input  wire logic             sys_clk_in,
  input  wire logic             nrst_in,
  // Pin levels and their synchronised copies.
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  // Only the second stage reads the first.
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
    end
    else
    begin
      meta_ff <= pin_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule

`default_nettype wire

//--- rtl/mode_decode.sv
// Operating mode decoder and address-region permission check.
// Assumes the status fields come straight from the status register.
`timescale 1ns/1ps
`default_nettype none

module mode_decode (
  // Status fields.
  input  wire logic [1:0]            privilege_field_in,
  input  wire logic                  exception_level_in,
  input  wire logic                  error_level_in,
  // Access query.
  input  wire status_ctl_pkg::region_t region_in,
  // Results.
  output status_ctl_pkg::mode_t      mode_out,
  output logic                       access_ok_out
);
  import status_ctl_pkg::*;

  // Either level forces kernel; otherwise the privilege field decides.
  always_comb
  begin
    if (exception_level_in || error_level_in)
      mode_out = MODE_KERNEL; // RULE_12
    else
    begin
      case (privilege_field_in)
        PRIV_KERNEL: mode_out = MODE_KERNEL; // RULE_12
        PRIV_SUPER:  mode_out = MODE_SUPER; // RULE_11
        PRIV_USER:   mode_out = MODE_USER; // RULE_10
        default:    mode_out = MODE_RSVD;
      endcase
    end
  end

  // Reserved mode is treated as least privileged.
  always_comb
  begin
    case (region_in)
      REGION_KERNEL: access_ok_out = (mode_out == MODE_KERNEL); // RULE_17
      REGION_SUPER:  access_ok_out = (mode_out == MODE_KERNEL) || (mode_out == MODE_SUPER); // RULE_17
      REGION_USER:   access_ok_out = 1'b1; // RULE_17
      default:       access_ok_out = 1'b0;
    endcase
  end

endmodule

`default_nettype wire

//--- bench/cpu_status_interrupt_mode_control_bench.sv
// Self-checking bench of the processor status control block, with an integer model.
// Assumes the status block answers on Avalon-MM at offsets 0x0, 0x4 and 0x8, with 0xc unmapped.
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin err_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module cpu_status_interrupt_mode_control_bench;
  import status_ctl_pkg::*;

  // Reserved status bits, which never hold a one.
  localparam logic [31:0] RSV = 32'h0b3863e0;

  logic        clk, nrst, av_rd, av_wr, av_wrq;
  logic [3:0]  av_addr, av_be;
  logic [31:0] av_wdata, av_rdata, bad_addr, q, w;
  logic [4:0]  ev;
  logic        timer, sdbg_pin, berr_exc, sdbg_exc, req, acc_ok, en;
  logic [1:0]  ext;
  logic [2:0]  take;
  region_t     region;
  mode_t       mode;
  int          err_count, total_checks, ms, mbad, e, n, i;

  status_ctl i_dut (
    .sys_clk_in                  (clk),
    .nrst_in                     (nrst),
    .avs_address_in              (av_addr),
    .avs_read_in                 (av_rd),
    .avs_write_in                (av_wr),
    .avs_writedata_in            (av_wdata),
    .avs_byteenable_in           (av_be),
    .avs_readdata_out            (av_rdata),
    .avs_waitrequest_out         (av_wrq),
    .enable_interrupts_instr_in  (ev[0]),
    .disable_interrupts_instr_in (ev[1]),
    .level2_exc_taken_in         (ev[2]),
    .general_exc_taken_in        (ev[3]),
    .bus_error_in                (ev[4]),
    .bus_error_addr_in           (bad_addr),
    .timer_intr_in               (timer),
    .ext_intr_in                 (ext),
    .serial_debug_input_in       (sdbg_pin),
    .access_region_in            (region),
    .intr_take_out               (take),
    .intr_req_out                (req),
    .bus_error_exc_out           (berr_exc),
    .serial_debug_exc_out        (sdbg_exc),
    .mode_out                    (mode),
    .access_ok_out               (acc_ok)
  );

  // Clock generator at 200 MHz.
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Expected one-hot mode from a status image.
  function automatic logic [3:0] emode(input logic [31:0] s);
    if (s[2] || s[1] || s[4:3] == 2'h0) return 4'h1;
    else if (s[4:3] == 2'h1) return 4'h2;
    else if (s[4:3] == 2'h2) return 4'h4;
    return 4'h8;
  endfunction

  // One bus cycle; the request stands until waitrequest is seen low at an edge.
  task automatic bus(input logic rd, input logic [3:0] a, input logic [31:0] d);
    logic ok;
    @(posedge clk);
    av_addr  <= a;
    av_wdata <= d;
    av_rd    <= rd;
    av_wr    <= !rd;
    ok = 1'b0;
    // Waitrequest and read data are taken at the rising edge itself; only the watchdog ends a hang.
    while (!ok)
    begin
      @(posedge clk);
      ok = (av_wrq === 1'b0);
      if (ok) q = av_rdata;
    end
    av_rd <= 1'b0;
    av_wr <= 1'b0;
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Watchdog that cuts a hang short.
  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    print_verdict();
  end

  // Main sequence.
  initial
  begin
    nrst = 1'b0; av_rd = 1'b0; av_wr = 1'b0; av_addr = 4'h0; av_be = 4'hf;
    av_wdata = 32'h0; ev = 5'h0; bad_addr = 32'h0; timer = 1'b0; ext = 2'h0;
    sdbg_pin = 1'b0; region = REGION_KERNEL; err_count = 0; total_checks = 0;
    void'($urandom(32'h1573fbbb));
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    // Reset image and unmapped offset reading zero.
    bus(1'b1, 4'h0, 32'h0);
    `CHK(q, 32'h00400004)
    ms = 32'h00400004;
    mbad = 0;
    bus(1'b1, 4'hc, 32'h0);
    `CHK(q, 32'h0)
    // Random status images, pins, queries and core events against the model.
    for (i = 0; i < 60; i++)
    begin
      w = $urandom;
      w[2:1] = {($urandom % 4) == 0, ($urandom % 4) == 0};
      av_be <= (i < 4) ? 4'hf : 4'($urandom);
      bus(1'b0, 4'h0, w);
      for (n = 0; n < 4; n++)
        if (av_be[n]) ms[8*n +: 8] = w[8*n +: 8] & ~RSV[8*n +: 8];
      timer <= 1'($urandom);
      ext <= 2'($urandom);
      region <= region_t'($urandom % 3);
      repeat (5) @(posedge clk);
      @(negedge clk);
      `CHK(mode, emode(ms))
      `CHK(acc_ok, region == REGION_USER || (region == REGION_SUPER && emode(ms) < 4'h4) ||
           emode(ms) == 4'h1)
      `CHK(take, {ms[15] & timer, ms[11] & ext[1], ms[10] & ext[0]} & {3{ms[0] & ms[16] &
           !ms[1] & !ms[2]}})
      `CHK(req, |take)
      // State word: enable, mode, pending sources, serial-debug level low.
      en = ms[0] & ms[16] & !ms[1] & !ms[2];
      bus(1'b1, 4'h8, 32'h0);
      `CHK(q, {21'h0, timer, ext, emode(ms), 3'h0, en})
      bus(1'b1, 4'h0, 32'h0);
      `CHK(q, 32'(ms))
      // At most one core event, applied to the model by its own rule.
      e = $urandom % 6;
      bad_addr <= $urandom;
      if (e < 2 && (ms[17] || emode(ms) == 4'h1)) ms[16] = (e == 0);
      if (e == 2) ms[2] = 1'b1;
      if (e == 3) ms[1] = 1'b1;
      @(posedge clk);
      ev <= (e < 5) ? 5'(1 << e) : 5'h0;
      @(posedge clk);
      ev <= 5'h0;
      @(negedge clk);
      `CHK(berr_exc, e == 4 && !ms[12])
      if (e == 4 && !ms[12])
      begin
        mbad = bad_addr;
        ms[12] = 1'b1;
      end
      bus(1'b1, 4'h4, 32'h0);
      `CHK(q, 32'(mbad))
      bus(1'b1, 4'h0, 32'h0);
      `CHK(q, 32'(ms))
    end
    // Serial-debug pin raised with error level clear, then set.
    for (i = 0; i < 2; i++)
    begin
      ms = i ? 32'h4 : 32'h0;
      av_be <= 4'hf;
      bus(1'b0, 4'h0, ms);
      @(posedge clk);
      sdbg_pin <= 1'b1;
      n = 0;
      repeat (8)
      begin
        @(negedge clk);
        if (sdbg_exc === 1'b1) n++;
      end
      `CHK(n, 1 - i)
      @(posedge clk);
      sdbg_pin <= 1'b0;
      repeat (4) @(posedge clk);
    end
    // A second reset in mid-run brings back the reset image.
    @(posedge clk);
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    `CHK(mode, MODE_KERNEL)
    bus(1'b1, 4'h0, 32'h0);
    `CHK(q, STATUS_RESET)
    print_verdict();
  end
endmodule

`default_nettype wire
